/* design/pdi_pkg.sv */
// constants and decode functions shared by the disconnect interrupt register block
package pdi_pkg;
	// register addresses on the ulpi register path
	localparam logic [5:0] ADR_OTG = 6'h0a;
	localparam logic [5:0] ADR_RISE = 6'h0d;
	localparam logic [5:0] ADR_FALL = 6'h10;
	localparam logic [5:0] ADR_STATUS = 6'h13;
	localparam logic [5:0] ADR_LATCH = 6'h14;
	localparam logic [5:0] ADR_DEBUG = 6'h15;
	localparam logic [5:0] ADR_SCRATCH = 6'h16;
	// offsets within a write/set/clear group
	localparam logic [5:0] OFS_SET = 6'h01;
	localparam logic [5:0] OFS_CLR = 6'h02;
	// field positions
	localparam int BIT_DISC = 0;
	localparam int BIT_PLUS_PD = 1;
	localparam int BIT_MINUS_PD = 2;
	// implemented-bit masks
	localparam logic [7:0] MSK_EN = 8'h01;
	localparam logic [7:0] MSK_OTG = 8'h06;
	localparam logic [7:0] MSK_SCRATCH = 8'hff;
	// values after reset
	localparam logic [7:0] RST_RISE = 8'h01;
	localparam logic [7:0] RST_FALL = 8'h01;
	localparam logic [7:0] RST_OTG = 8'h06;
	localparam logic [7:0] RST_SCRATCH = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;
	// transmit command codes in data[7:6]
	localparam logic [1:0] CMD_REG_WRITE = 2'h2;
	localparam logic [1:0] CMD_REG_READ = 2'h3;
	// width of the pin synchroniser bundle
	localparam int SYNC_W = 13;

	// true when adr falls in the three-address group starting at base
	function automatic logic pdi_in_group(input logic [5:0] adr, input logic [5:0] base);
		return (adr >= base) && (adr <= base + OFS_CLR);
	endfunction : pdi_in_group

	// next value of a write/set/clear register for one committed write
	function automatic logic [7:0] pdi_apply(input logic [7:0] cur, input logic [7:0] wd,
		input logic [5:0] adr, input logic [5:0] base, input logic [7:0] msk);
		logic [7:0] res;
		res = cur;
		if (adr == base) begin
			res = wd & msk;
		end else if (adr == base + OFS_SET) begin
			res = (cur | wd) & msk;
		end else if (adr == base + OFS_CLR) begin
			res = cur & ~wd & msk;
		end
		return res;
	endfunction : pdi_apply
endpackage : pdi_pkg

/* design/pdi_sync.sv */
// two-flop synchroniser bank for pins arriving from outside the clock domain
module pdi_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					meta_r[g] <= 1'b0;
					o_q[g] <= 1'b0;
				end else begin
					meta_r[g] <= i_d[g];
					o_q[g] <= meta_r[g];
				end
			end
		end
	endgenerate
endmodule : pdi_sync

/* design/pdi_regs_top.sv */
// disconnect interrupt, debug and scratch registers behind a ulpi register port
module pdi_regs_top
	import pdi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ulpi_clk,
	input wire logic [7:0] i_ulpi_data,
	input wire logic i_ulpi_stp,
	input wire logic i_host_disconnect,
	input wire logic i_line_level_bit_low,
	input wire logic i_line_level_bit_high,
	output logic o_ulpi_dir,
	output logic o_ulpi_nxt,
	output logic [7:0] o_ulpi_data,
	output logic o_ulpi_data_oe,
	output logic o_plus_line_pulldown_en,
	output logic o_minus_line_pulldown_en,
	output logic o_disc_event
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_W_DATA,
		ST_W_STOP,
		ST_R_TURN,
		ST_R_DATA,
		ST_R_END
	} pdi_state_t;

	pdi_state_t state_r, state_nxt;
	logic [SYNC_W-1:0] sync_q;
	logic lk_s, stp_s, hd_s, ls0_s, ls1_s;
	logic [7:0] dat_s;
	logic lk_d_r, hd_d_r;
	logic [5:0] adr_r;
	logic [7:0] wdat_r;
	logic [7:0] rise_r, fall_r, otg_r, scratch_r, latch_r;
	logic [7:0] rise_nxt, fall_nxt, otg_nxt, scratch_nxt, latch_nxt;

	// every pin, the link clock included, is brought in through two flops
	pdi_sync #(
		.W(SYNC_W)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_ulpi_clk, i_ulpi_stp, i_ulpi_data, i_host_disconnect,
			i_line_level_bit_high, i_line_level_bit_low}),
		.o_q(sync_q)
	);

	// unpack the synchronised bundle
	assign lk_s = sync_q[12];
	assign stp_s = sync_q[11];
	assign dat_s = sync_q[10:3];
	assign hd_s = sync_q[2];
	assign ls1_s = sync_q[1];
	assign ls0_s = sync_q[0];

	// link clock rising edge; data is sampled on it since both took equal delay
	wire lk_rise = lk_s & ~lk_d_r;

	// host mode needs both pulldowns enabled
	wire host_mode = otg_r[BIT_PLUS_PD] & otg_r[BIT_MINUS_PD];
	wire hd_rise = hd_s & ~hd_d_r;
	wire hd_fall = ~hd_s & hd_d_r;
	wire rise_ev = host_mode & rise_r[BIT_DISC] & hd_rise;
	wire fall_ev = host_mode & fall_r[BIT_DISC] & hd_fall;
	wire disc_ev = rise_ev | fall_ev;

	// command decode on an idle link edge
	wire cmd_wr = (dat_s[7:6] == CMD_REG_WRITE);
	wire cmd_rd = (dat_s[7:6] == CMD_REG_READ);

	// a write commits when the link raises stop after the data byte
	wire wr_fire = lk_rise & (state_r == ST_W_STOP) & stp_s;
	// a read takes effect in the cycle its byte is put on the bus
	wire rd_fire = lk_rise & (state_r == ST_R_TURN);
	wire rd_latch = rd_fire & (adr_r == ADR_LATCH);

	// read data selection; unmapped addresses read zero
	wire sel_otg = pdi_in_group(adr_r, ADR_OTG);
	wire sel_rise = pdi_in_group(adr_r, ADR_RISE);
	wire sel_fall = pdi_in_group(adr_r, ADR_FALL);
	wire sel_scr = pdi_in_group(adr_r, ADR_SCRATCH);
	wire [7:0] status_val = {7'h00, hd_s};
	wire [7:0] debug_val = {6'h00, ls1_s, ls0_s};
	wire [7:0] rd_val = sel_otg ? otg_r :
		sel_rise ? rise_r :
		sel_fall ? fall_r :
		sel_scr ? scratch_r :
		(adr_r == ADR_STATUS) ? status_val :
		(adr_r == ADR_LATCH) ? latch_r :
		(adr_r == ADR_DEBUG) ? debug_val : 8'h00;

	// register write paths; status, latch and debug addresses have no write path
	assign otg_nxt = wr_fire ? pdi_apply(otg_r, wdat_r, adr_r, ADR_OTG, MSK_OTG) : otg_r;
	assign rise_nxt = wr_fire ? pdi_apply(rise_r, wdat_r, adr_r, ADR_RISE, MSK_EN) : rise_r;
	assign fall_nxt = wr_fire ? pdi_apply(fall_r, wdat_r, adr_r, ADR_FALL, MSK_EN) : fall_r;
	// scratch reaches nothing but its own read path
	assign scratch_nxt = wr_fire ?
		pdi_apply(scratch_r, wdat_r, adr_r, ADR_SCRATCH, MSK_SCRATCH) : scratch_r;
	// an event in the clearing read cycle survives: set wins over clear
	assign latch_nxt = {7'h00, (latch_r[BIT_DISC] & ~rd_latch) | disc_ev};

	// link protocol sequencing, advanced only on link clock edges
	always_comb begin
		state_nxt = state_r;
		if (lk_rise) begin
			case (state_r)
				ST_IDLE: begin
					if (cmd_wr) begin
						state_nxt = ST_W_DATA;
					end else if (cmd_rd) begin
						state_nxt = ST_R_TURN;
					end
				end
				ST_W_DATA: state_nxt = stp_s ? ST_IDLE : ST_W_STOP;
				ST_W_STOP: state_nxt = stp_s ? ST_IDLE : ST_W_STOP;
				ST_R_TURN: state_nxt = ST_R_DATA;
				ST_R_DATA: state_nxt = ST_R_END;
				ST_R_END: state_nxt = ST_IDLE;
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// state and edge history
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			lk_d_r <= 1'b0;
			hd_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			lk_d_r <= lk_s;
			hd_d_r <= hd_s;
		end
	end

	// captured address and write byte
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adr_r <= 6'h00;
			wdat_r <= 8'h00;
		end else if (lk_rise && state_r == ST_IDLE && (cmd_wr || cmd_rd)) begin
			adr_r <= dat_s[5:0];
		end else if (lk_rise && state_r == ST_W_DATA) begin
			wdat_r <= dat_s;
		end
	end

	// register file
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			otg_r <= RST_OTG;
			rise_r <= RST_RISE;
			fall_r <= RST_FALL;
			scratch_r <= RST_SCRATCH;
			latch_r <= RST_LATCH;
		end else begin
			otg_r <= otg_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			scratch_r <= scratch_nxt;
			latch_r <= latch_nxt;
		end
	end

	// ulpi outputs; nxt acknowledges the command byte of a write or of a read
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ulpi_dir <= 1'b0;
			o_ulpi_nxt <= 1'b0;
			o_ulpi_data <= 8'h00;
			o_ulpi_data_oe <= 1'b0;
		end else if (lk_rise) begin
			o_ulpi_nxt <= (state_nxt == ST_W_DATA) || (state_nxt == ST_R_TURN);
			// dir rises with the read byte and stays up one undriven period after it
			o_ulpi_dir <= (state_nxt == ST_R_DATA) || (state_nxt == ST_R_END);
			o_ulpi_data_oe <= (state_nxt == ST_R_DATA);
			o_ulpi_data <= (state_nxt == ST_R_DATA) ? rd_val : 8'h00;
		end
	end

	// side outputs straight from flops
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_plus_line_pulldown_en <= RST_OTG[BIT_PLUS_PD];
			o_minus_line_pulldown_en <= RST_OTG[BIT_MINUS_PD];
			o_disc_event <= 1'b0;
		end else begin
			o_plus_line_pulldown_en <= otg_r[BIT_PLUS_PD];
			o_minus_line_pulldown_en <= otg_r[BIT_MINUS_PD];
			o_disc_event <= disc_ev;
		end
	end

	// enabled rising edge in host mode must set the latch
	a_latch_rise_set: assert property (@(posedge i_clk) disable iff (i_rst)
		(host_mode && rise_r[BIT_DISC] && hd_s && !hd_d_r) |=> latch_r[BIT_DISC])
		else $error("enabled rising disconnect edge did not set latch");

	a_latch_fall_set: assert property (@(posedge i_clk) disable iff (i_rst)
		(host_mode && fall_r[BIT_DISC] && !hd_s && hd_d_r) |=> latch_r[BIT_DISC])
		else $error("enabled falling disconnect edge did not set latch");

	a_event_host_only: assert property (@(posedge i_clk) disable iff (i_rst)
		!(otg_r[BIT_PLUS_PD] && otg_r[BIT_MINUS_PD]) |=> !o_disc_event)
		else $error("disconnect event outside host mode");

	a_latch_masked: assert property (@(posedge i_clk) disable iff (i_rst)
		(!latch_r[BIT_DISC] && !(rise_r[BIT_DISC] && hd_s && !hd_d_r)
		&& !(fall_r[BIT_DISC] && !hd_s && hd_d_r)) |=> !latch_r[BIT_DISC])
		else $error("latch set without an enabled edge");

	a_latch_read_clr: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_fire && adr_r == ADR_LATCH && !(hd_s ^ hd_d_r)) |=> !latch_r[BIT_DISC])
		else $error("latch not cleared by read");

	a_rise_set_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_RISE + OFS_SET) |=>
		rise_r[BIT_DISC] == ($past(rise_r[BIT_DISC]) | $past(wdat_r[BIT_DISC])))
		else $error("rise enable set access wrong");

	a_fall_clr_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_FALL + OFS_CLR) |=>
		fall_r[BIT_DISC] == ($past(fall_r[BIT_DISC]) & ~$past(wdat_r[BIT_DISC])))
		else $error("fall enable clear access wrong");

	a_debug_upper_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_fire && adr_r == ADR_DEBUG) |=> (o_ulpi_data[7:2] == 6'h00 && o_ulpi_data_oe))
		else $error("debug read upper bits not zero");

	a_scratch_isolated: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && pdi_in_group(adr_r, ADR_SCRATCH)) |=>
		($stable(rise_r) && $stable(fall_r) && $stable(otg_r)))
		else $error("scratch write disturbed another register");

	a_status_no_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_STATUS) |=>
		($stable(rise_r) && $stable(fall_r) && $stable(otg_r) && $stable(scratch_r)))
		else $error("status write changed state");

	a_read_turnaround: assert property (@(posedge i_clk) disable iff (i_rst)
		(lk_rise && state_r == ST_IDLE && cmd_rd) |-> ##[1:40] o_ulpi_data_oe)
		else $error("read byte not driven in time");

	a_oe_needs_dir: assert property (@(posedge i_clk) disable iff (i_rst)
		o_ulpi_data_oe |-> o_ulpi_dir)
		else $error("data driven without dir");

	// scratch plain, set and clear writes land exactly as addressed
	a_scratch_plain_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_SCRATCH) |=> scratch_r == $past(wdat_r))
		else $error("scratch plain write wrong");

	a_scratch_set_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_SCRATCH + OFS_SET) |=>
		scratch_r == ($past(scratch_r) | $past(wdat_r)))
		else $error("scratch set write wrong");

	a_scratch_clr_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_SCRATCH + OFS_CLR) |=>
		scratch_r == ($past(scratch_r) & ~$past(wdat_r)))
		else $error("scratch clear write wrong");

	// enable groups keep only their one implemented bit
	a_rise_plain_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_RISE) |=> rise_r == ($past(wdat_r) & MSK_EN))
		else $error("rise enable plain write wrong");

	a_rise_clr_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_RISE + OFS_CLR) |=>
		rise_r[BIT_DISC] == ($past(rise_r[BIT_DISC]) & ~$past(wdat_r[BIT_DISC])))
		else $error("rise enable clear access wrong");

	a_fall_plain_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_FALL) |=> fall_r == ($past(wdat_r) & MSK_EN))
		else $error("fall enable plain write wrong");

	a_fall_set_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_FALL + OFS_SET) |=>
		fall_r[BIT_DISC] == ($past(fall_r[BIT_DISC]) | $past(wdat_r[BIT_DISC])))
		else $error("fall enable set access wrong");

	// the control register holds nothing but the two pulldown bits
	a_otg_plain_wr: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_fire && adr_r == ADR_OTG) |=> otg_r == ($past(wdat_r) & MSK_OTG))
		else $error("control plain write wrong");

	a_pulldown_follow: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_plus_line_pulldown_en == $past(otg_r[BIT_PLUS_PD]))
		&& (o_minus_line_pulldown_en == $past(otg_r[BIT_MINUS_PD])))
		else $error("pulldown outputs do not follow control bits");

	// read bytes carry the values seen in the read cycle itself
	a_status_read_val: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_fire && adr_r == ADR_STATUS) |=> o_ulpi_data == {7'h00, $past(hd_s)})
		else $error("status read byte wrong");

	a_debug_read_live: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_fire && adr_r == ADR_DEBUG) |=> o_ulpi_data[1:0] == {$past(ls1_s), $past(ls0_s)})
		else $error("debug read not the live line state");

	a_latch_read_val: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_fire && adr_r == ADR_LATCH) |=> o_ulpi_data == $past(latch_r))
		else $error("latch read byte wrong");

	a_latch_upper_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		latch_r[7:1] == 7'h00)
		else $error("latch upper bits not zero");
endmodule : pdi_regs_top

/* dv/pdi_link_model.sv */
// link-side model of the ulpi register path
module pdi_link_model
	import pdi_pkg::*;
(
	output logic o_lclk,
	output logic [7:0] o_data,
	output logic o_stp,
	input wire logic i_dir,
	input wire logic i_nxt,
	input wire logic [7:0] i_data,
	input wire logic i_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// free-running link clock, offset 3 ns; its 64 ns period is eight system clocks, so its edges keep a fixed phase against the system clock
	initial begin
		o_lclk = 1'b0;
		o_data = 8'h00;
		o_stp = 1'b0;
		#3;
		forever #32 o_lclk = ~o_lclk;
	end

	// the block oversamples our pins, so moving them mid-period keeps clear of its sampling
	task automatic put(input logic [7:0] d, input logic s);
		@(negedge o_lclk);
		o_data = d;
		o_stp = s;
		@(posedge o_lclk);
	endtask : put

	// register write; abort raises stop beside the data byte so nothing commits
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic ab, output logic ok);
		put({CMD_REG_WRITE, a}, 1'b0);
		put(d, ab);
		ok = i_nxt;
		put(8'h00, 1'b1);
		ok &= ~i_nxt;
		@(negedge o_lclk);
		o_stp = 1'b0;
	endtask : wr

	// register read: dir and the byte arrive together, one undriven period follows
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		put({CMD_REG_READ, a}, 1'b0);
		put(8'h00, 1'b0);
		ok = i_nxt;
		@(posedge o_lclk);
		ok &= i_dir & i_oe & ~i_nxt;
		d = i_data;
		@(posedge o_lclk);
		ok &= i_dir & ~i_oe;
		@(posedge o_lclk);
		ok &= ~i_dir;
	endtask : rd
endmodule : pdi_link_model

/* dv/test_phy_disconnect_interrupt_regs.sv */
// self-checking bench for the disconnect interrupt register block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_phy_disconnect_interrupt_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, disc, ls_lo, ls_hi, lclk, stp, dir, nxt, oe, pu, pd, ev, ok;
	logic [7:0] ldat, ddat, rv;
	int bad_count = 0;
	int total_checks = 0;
	int evs = 0;
	int e0;
	logic [5:0] adr [16] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11,
		6'h12, 6'h13, 6'h14, 6'h16, 6'h17, 6'h18, 6'h20, 6'h3f};
	logic [7:0] val [16] = '{8'h06, 8'h06, 8'h06, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// count event pulses so scenarios compare counts, not single samples
	always @(negedge clk) begin
		if (ev === 1'b1) evs++;
	end

	pdi_regs_top i_pdi_regs_top (.i_clk(clk), .i_rst(rst), .i_ulpi_clk(lclk),
		.i_ulpi_data(ldat), .i_ulpi_stp(stp), .i_host_disconnect(disc),
		.i_line_level_bit_low(ls_lo), .i_line_level_bit_high(ls_hi), .o_ulpi_dir(dir),
		.o_ulpi_nxt(nxt), .o_ulpi_data(ddat), .o_ulpi_data_oe(oe),
		.o_plus_line_pulldown_en(pu), .o_minus_line_pulldown_en(pd), .o_disc_event(ev));

	pdi_link_model i_pdi_link_model (.o_lclk(lclk), .o_data(ldat), .o_stp(stp),
		.i_dir(dir), .i_nxt(nxt), .i_data(ddat), .i_oe(oe));

	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		i_pdi_link_model.rd(a, rv, ok);
		`CHK("read handshake", 1'b1, ok)
		`CHK("read data", e, rv)
	endtask : rchk

	// write, then let the commit pass through the output flops
	task automatic w(input logic [5:0] a, input logic [7:0] d, input logic ab);
		i_pdi_link_model.wr(a, d, ab, ok);
		`CHK("write handshake", 1'b1, ok)
		repeat (6) @(negedge clk);
	endtask : w

	// move the disconnect level and count events over a fixed observation window
	task automatic edge_ev(input logic lvl, input int n);
		@(negedge clk);
		disc = lvl;
		e0 = evs;
		repeat (12) @(negedge clk);
		`CHK("event count", n, evs - e0)
	endtask : edge_ev

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	initial begin
		rst = 1'b1;
		disc = 1'b0;
		ls_lo = 1'b0;
		ls_hi = 1'b0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("pulldowns", 2'b11, {pu, pd})
		for (int k = 0; k < 16; k++) rchk(adr[k], val[k]);
		w(6'h16, 8'ha5, 1'b0);
		w(6'h17, 8'h0a, 1'b0);
		w(6'h18, 8'h0f, 1'b0);
		w(6'h16, 8'h33, 1'b1);
		for (int k = 6'h16; k <= 6'h18; k++) rchk(k[5:0], 8'ha0);
		`CHK("pulldowns", 2'b11, {pu, pd})
		for (int k = 6'h13; k <= 6'h15; k++) w(k[5:0], 8'hff, 1'b0);
		rchk(6'h14, 8'h00);
		rchk(6'h13, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			ls_lo = k[0];
			ls_hi = k[1];
			rchk(6'h15, {6'h00, k[1:0]});
		end
		edge_ev(1'b1, 1);
		rchk(6'h13, 8'h01);
		rchk(6'h14, 8'h01);
		rchk(6'h14, 8'h00);
		edge_ev(1'b0, 1);
		rchk(6'h14, 8'h01);
		w(6'h0f, 8'h01, 1'b0);
		edge_ev(1'b1, 0);
		rchk(6'h14, 8'h00);
		w(6'h12, 8'h01, 1'b0);
		edge_ev(1'b0, 0);
		rchk(6'h10, 8'h00);
		w(6'h11, 8'h01, 1'b0);
		rchk(6'h12, 8'h01);
		w(6'h0e, 8'h01, 1'b0);
		w(6'h10, 8'h01, 1'b0);
		rchk(6'h0d, 8'h01);
		w(6'h0c, 8'h02, 1'b0);
		`CHK("pulldowns", 2'b01, {pu, pd})
		edge_ev(1'b1, 0);
		rchk(6'h13, 8'h01);
		rchk(6'h14, 8'h00);
		w(6'h0b, 8'h02, 1'b0);
		edge_ev(1'b0, 1);
		w(6'h0a, 8'h00, 1'b0);
		`CHK("pulldowns", 2'b00, {pu, pd})
		// a second reset mid-run must bring the control, scratch and fall enable registers back
		@(negedge clk);
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("pulldowns", 2'b11, {pu, pd})
		rchk(6'h16, 8'h00);
		rchk(6'h10, 8'h01);
		results();
	end
endmodule : test_phy_disconnect_interrupt_regs
